/* hdl/uh_cfg_top.sv */
// mode and hardware configuration registers of the usb peripheral
`timescale 1ns/100ps
`default_nettype none
`include "uh_params.svh"
module uh_cfg_top #(
	parameter int SUSP_CYC = `UH_SUSP_CYC
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_usb_bus_reset,
	input  wire logic        i_bus_16bit,
	input  wire logic        i_cmd_valid,
	input  wire logic        i_data_wr,
	input  wire logic        i_data_rd,
	input  wire logic [15:0] i_wdata,
	output logic      [15:0] o_rdata,
	input  wire logic        i_otg_mode,
	input  wire logic        i_local_connect,
	input  wire logic        i_evt_ack_bulk,
	input  wire logic        i_evt_iso_done,
	input  wire logic        i_evt_nak,
	input  wire logic        i_evt_err,
	input  wire logic        i_irq_clear,
	input  wire logic        i_resume,
	input  wire logic        i_cs_n,
	input  wire logic        i_dma_request,
	input  wire logic        i_dma_ack_pin,
	output logic             o_dma_request_pin,
	output logic             o_dma_ack,
	output logic             o_ack_only_dma_mode,
	output logic             o_port1_dplus_pullup,
	output logic             o_divided_clock_pin,
	output logic             o_peripheral_irq_pin,
	output logic             o_suspended,
	output logic             o_osc_pll_stop,
	output logic             o_remote_wakeup
);
	localparam int SW = $clog2(SUSP_CYC + 1);
	localparam logic [SW-1:0] SUSP_LAST = SW'(SUSP_CYC - 1);

	uh_pkg::uh_cmd_e  cmd_q;
	uh_pkg::uh_cmd_e  cmd_d;
	uh_pkg::uh_susp_e susp_q;
	logic [7:0]       mode_q;
	logic [15:0]      hw_q;
	logic [7:0]       hw_lo_q;
	logic [SW-1:0]    scnt_q;
	logic             wr_go;
	logic             rd_go;
	logic             mode_wr_go;
	logic             hw_wr_go;
	logic [15:0]      hw_wdata;
	logic             susp_req;
	logic             cs_wake;
	logic             wake;

	uh_ctl_if ctl_bus ();

	// -----------------------------------------------------------------
	// command decoding
	// -----------------------------------------------------------------
	// codes outside this bank leave the sequencer idle; other banks
	// answer them, so nothing here reacts to their data bytes
	function automatic uh_pkg::uh_cmd_e cmd_decode(input logic [7:0] code);
		uh_pkg::uh_cmd_e st;
		st = uh_pkg::uh_st_idle;
		unique case (code)
			`UH_CMD_MODE_WR: st = uh_pkg::uh_st_mode_wr;   // [RL1]
			`UH_CMD_MODE_RD: st = uh_pkg::uh_st_mode_rd;   // [RL1]
			`UH_CMD_HW_WR:   st = uh_pkg::uh_st_hw_wr_lo;  // [RL10]
			`UH_CMD_HW_RD:   st = uh_pkg::uh_st_hw_rd_lo;  // [RL10]
			default:         st = uh_pkg::uh_st_idle;
		endcase
		return st;
	endfunction : cmd_decode

	// read data presented for a given sequencer state
	function automatic logic [15:0] read_word(
		input uh_pkg::uh_cmd_e st,
		input logic [7:0]      mode,
		input logic [15:0]     hw,
		input logic            wide
	);
		logic [15:0] w;
		w = 16'h0000;
		unique case (st)
			uh_pkg::uh_st_mode_rd:  w = {8'h00, mode};           // [RL2]
			uh_pkg::uh_st_hw_rd_lo: w = wide ? hw : {8'h00, hw[7:0]};
			uh_pkg::uh_st_hw_rd_hi: w = {8'h00, hw[15:8]};       // [RL11]
			default:                w = 16'h0000;
		endcase
		return w;
	endfunction : read_word

	// -----------------------------------------------------------------
	// transfer sequencer
	// -----------------------------------------------------------------
	// a command strobe always wins, so a new code aborts an open transfer
	assign wr_go = i_data_wr & !i_cmd_valid;
	assign rd_go = i_data_rd & !i_cmd_valid;

	always_comb
	begin
		cmd_d = cmd_q;
		if (i_cmd_valid)
			cmd_d = cmd_decode(i_wdata[7:0]);
		else
		begin
			unique case (cmd_q)
				uh_pkg::uh_st_idle: cmd_d = cmd_q;
				uh_pkg::uh_st_mode_wr:
					if (i_data_wr) cmd_d = uh_pkg::uh_st_idle;
				uh_pkg::uh_st_hw_wr_lo:
					if (i_data_wr)
						cmd_d = i_bus_16bit ? uh_pkg::uh_st_idle
							: uh_pkg::uh_st_hw_wr_hi;          // [RL10]
				uh_pkg::uh_st_hw_wr_hi:
					if (i_data_wr) cmd_d = uh_pkg::uh_st_idle;
				uh_pkg::uh_st_mode_rd:
					if (i_data_rd) cmd_d = uh_pkg::uh_st_idle;
				uh_pkg::uh_st_hw_rd_lo:
					if (i_data_rd)
						cmd_d = i_bus_16bit ? uh_pkg::uh_st_idle
							: uh_pkg::uh_st_hw_rd_hi;          // [RL10]
				uh_pkg::uh_st_hw_rd_hi:
					if (i_data_rd) cmd_d = uh_pkg::uh_st_idle;
				default: cmd_d = uh_pkg::uh_st_idle;
			endcase
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			cmd_q <= uh_pkg::uh_st_idle;
		else
			cmd_q <= cmd_d;
	end

	// read data follows the next state so it stands from the edge after
	// the command or the previous byte
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			o_rdata <= 16'h0000;
		else
			o_rdata <= read_word(cmd_d, mode_q, hw_q, i_bus_16bit);
	end

	// -----------------------------------------------------------------
	// mode register
	// -----------------------------------------------------------------
	assign mode_wr_go = wr_go && (cmd_q == uh_pkg::uh_st_mode_wr);
	// only a written 1-to-0 change counts; bus reset clearing the bit
	// or a repeated 0 write does not start suspend
	assign susp_req = mode_wr_go && mode_q[`UH_MODE_SUSP_BIT]
		&& !i_wdata[`UH_MODE_SUSP_BIT];                          // [RL4] [RL24]

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			mode_q <= `UH_MODE_RST;                               // [RL3]
		else if (mode_wr_go)
			mode_q <= i_wdata[7:0];                               // [RL2]
		else if (i_usb_bus_reset)
			mode_q <= mode_q & `UH_MODE_BUS_KEEP;                 // [RL3]
	end

	// -----------------------------------------------------------------
	// hardware configuration register
	// -----------------------------------------------------------------
	// both bytes land together so the divider never sees half a value
	assign hw_wr_go = wr_go && ((cmd_q == uh_pkg::uh_st_hw_wr_hi)
		|| (cmd_q == uh_pkg::uh_st_hw_wr_lo && i_bus_16bit));
	assign hw_wdata = (cmd_q == uh_pkg::uh_st_hw_wr_hi)
		? {i_wdata[7:0], hw_lo_q} : i_wdata;                     // [RL10]

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			hw_lo_q <= 8'h00;
		else if (wr_go && !i_bus_16bit
			&& cmd_q == uh_pkg::uh_st_hw_wr_lo)
			hw_lo_q <= i_wdata[7:0];
	end

	// bus reset is not an input here at all
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			hw_q <= `UH_HW_RST;                                   // [RL13]
		else if (hw_wr_go)
			hw_q <= hw_wdata & `UH_HW_WMASK;                      // [RL11] [RL12]
	end

	// -----------------------------------------------------------------
	// suspend sequencing
	// -----------------------------------------------------------------
	assign cs_wake = hw_q[`UH_HW_CS_WAKE_BIT] && !i_cs_n
		&& (susp_q != uh_pkg::uh_su_run);                        // [RL23]
	assign wake = i_resume | i_usb_bus_reset | cs_wake;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			susp_q <= uh_pkg::uh_su_run;
			scnt_q <= '0;
		end
		else
		begin
			unique case (susp_q)
				uh_pkg::uh_su_run:
					if (susp_req)
					begin
						susp_q <= uh_pkg::uh_su_wait;              // [RL4]
						scnt_q <= '0;
					end
				uh_pkg::uh_su_wait:
					if (wake)
						susp_q <= uh_pkg::uh_su_run;
					else if (scnt_q == SUSP_LAST)
						susp_q <= uh_pkg::uh_su_sleep;             // [RL15] [RL16]
					else
						scnt_q <= scnt_q + SW'(1);
				uh_pkg::uh_su_sleep:
					if (wake)
						susp_q <= uh_pkg::uh_su_run;
				default: susp_q <= uh_pkg::uh_su_run;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// clock and interrupt controls
	// -----------------------------------------------------------------
	// firmware is trusted to clear keep-clocks before suspending; if it
	// does not, the oscillator simply keeps running
	assign ctl_bus.clk_div   = hw_q[`UH_HW_DIV_MSB:`UH_HW_DIV_LSB];
	assign ctl_bus.clk_run   = (susp_q != uh_pkg::uh_su_sleep);
	assign ctl_bus.clk_slow  = (susp_q == uh_pkg::uh_su_sleep)
		&& !hw_q[`UH_HW_SLOW_DIS_BIT];                           // [RL15]
	assign ctl_bus.irq_evt   = mode_q[`UH_MODE_DIAG_BIT]
		? (i_evt_nak | i_evt_err)                                // [RL6]
		: (i_evt_ack_bulk | i_evt_iso_done);                     // [RL7]
	assign ctl_bus.irq_en    = mode_q[`UH_MODE_IRQ_ON_BIT];      // [RL5]
	assign ctl_bus.irq_pulse = hw_q[`UH_HW_PULSE_BIT];
	assign ctl_bus.irq_pol   = hw_q[`UH_HW_POL_BIT];
	assign ctl_bus.irq_clear = i_irq_clear;

	uh_divided_clock_pin u_divided_clock_pin (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.ctl        (ctl_bus.clkgen),
		.o_clk_pin  (o_divided_clock_pin)
	);

	uh_irq_out u_irq (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.ctl        (ctl_bus.irqgen),
		.o_irq_pin  (o_peripheral_irq_pin)
	);

	// -----------------------------------------------------------------
	// pin outputs
	// -----------------------------------------------------------------
	// registered pins; reset values follow the register reset state
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			o_dma_request_pin    <= 1'b0;
			o_dma_ack            <= 1'b0;
			o_ack_only_dma_mode  <= 1'b0;
			o_port1_dplus_pullup <= 1'b0;
			o_suspended          <= 1'b0;
			o_osc_pll_stop       <= 1'b0;
			o_remote_wakeup      <= 1'b0;
		end
		else
		begin
			o_dma_request_pin <= hw_q[`UH_HW_REQ_POL_BIT]
				? i_dma_request : !i_dma_request;                // [RL22]
			o_dma_ack <= hw_q[`UH_HW_ACK_POL_BIT]
				? i_dma_ack_pin : !i_dma_ack_pin;                // [RL22]
			o_ack_only_dma_mode <= hw_q[`UH_HW_ACK_ONLY_BIT];    // [RL22]
			o_port1_dplus_pullup <= i_otg_mode ? i_local_connect // [RL9]
				: (!hw_q[`UH_HW_EXT_PULL_BIT]
				&& mode_q[`UH_MODE_SOFT_BIT]);                   // [RL8] [RL14]
			o_suspended <= (susp_q != uh_pkg::uh_su_run);
			o_osc_pll_stop <= (susp_q == uh_pkg::uh_su_sleep)
				&& !hw_q[`UH_HW_KEEP_CLK_BIT];                   // [RL16]
			o_remote_wakeup <= cs_wake;                          // [RL23]
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	a_mode_rst_val: assert property ( // [RL3]
		$rose(i_reset_n) |-> mode_q == `UH_MODE_RST)
		else $error("mode register reset value wrong");
	a_mode_wr_byte: assert property ( // [RL2]
		mode_wr_go |=> mode_q == $past(i_wdata[7:0]))
		else $error("mode write lost or took upper byte");
	a_mode_bus_keep: assert property ( // [RL3]
		i_usb_bus_reset && !mode_wr_go
		|=> mode_q == ($past(mode_q) & `UH_MODE_BUS_KEEP))
		else $error("bus reset changed kept mode bits");
	a_susp_on_fall: assert property ( // [RL4]
		susp_req && susp_q == uh_pkg::uh_su_run
		|=> susp_q == uh_pkg::uh_su_wait ##1 o_suspended)
		else $error("suspend not entered after 1-0 write");
	a_no_susp_zero: assert property ( // [RL24]
		mode_wr_go && !mode_q[`UH_MODE_SUSP_BIT]
		&& susp_q == uh_pkg::uh_su_run |=> susp_q == uh_pkg::uh_su_run)
		else $error("suspend entered without a 1-0 write");
	a_diag_no_ack: assert property ( // [RL6]
		mode_q[`UH_MODE_DIAG_BIT] && !i_evt_nak && !i_evt_err
		|-> !ctl_bus.irq_evt)
		else $error("diagnostic mode took a normal event");
	a_norm_no_nak: assert property ( // [RL7]
		!mode_q[`UH_MODE_DIAG_BIT] && !i_evt_ack_bulk && !i_evt_iso_done
		|-> !ctl_bus.irq_evt)
		else $error("normal mode took a nak or error");
	a_ext_pull_off: assert property ( // [RL8]
		!i_otg_mode && hw_q[`UH_HW_EXT_PULL_BIT] |=> !o_port1_dplus_pullup)
		else $error("soft pull-up on despite external pull-up");
	a_otg_pull: assert property ( // [RL9]
		i_otg_mode |=> o_port1_dplus_pullup == $past(i_local_connect))
		else $error("otg pull-up not following local connect");
	a_hw_two_byte: assert property ( // [RL10]
		hw_wr_go && cmd_q == uh_pkg::uh_st_hw_wr_hi
		|=> hw_q == ({$past(i_wdata[7:0]), $past(hw_lo_q)} & `UH_HW_WMASK))
		else $error("config register byte pairing wrong");
	a_hw_bus_keep: assert property ( // [RL12]
		!hw_wr_go |=> $stable(hw_q))
		else $error("config register changed without a write");
	a_hw_rst_val: assert property ( // [RL13]
		$rose(i_reset_n) |-> hw_q == `UH_HW_RST)
		else $error("config register reset value wrong");
	a_susp_delay: assert property ( // [RL15]
		susp_q == uh_pkg::uh_su_wait && scnt_q == SUSP_LAST && !wake
		|=> susp_q == uh_pkg::uh_su_sleep)
		else $error("suspend delay count wrong");
	a_osc_stop: assert property ( // [RL16]
		susp_q == uh_pkg::uh_su_sleep && !hw_q[`UH_HW_KEEP_CLK_BIT]
		|=> o_osc_pll_stop)
		else $error("oscillator not stopped in suspend");
	a_dma_req_pol: assert property ( // [RL22]
		!hw_q[`UH_HW_REQ_POL_BIT] |=> o_dma_request_pin == !$past(i_dma_request))
		else $error("dma request polarity wrong");
	a_cs_wake: assert property ( // [RL23]
		cs_wake |=> susp_q == uh_pkg::uh_su_run && o_remote_wakeup)
		else $error("chip-select wake-up ignored");

	c_susp_enter: cover property (susp_q == uh_pkg::uh_su_sleep);
	c_hw_wr_8bit: cover property (hw_wr_go && !i_bus_16bit);
	c_cs_wake:    cover property (cs_wake);
	c_mode_rd:    cover property (rd_go && cmd_q == uh_pkg::uh_st_mode_rd);
endmodule : uh_cfg_top
`default_nettype wire

/* hdl/uh_divided_clock_pin.sv */
// glitch-free divided clock output with slow suspend clock option
`timescale 1ns/100ps
`default_nettype none
`include "uh_params.svh"
module uh_divided_clock_pin (
	input  wire logic  i_core_clk,
	input  wire logic  i_reset_n,
	uh_ctl_if.clkgen   ctl,
	output logic       o_clk_pin
);
	localparam logic [5:0] SLOW_HALF = 6'(`UH_SLOW_HALF_CYC - 1);
	logic [5:0] cnt_q;
	logic [5:0] half_q;
	logic       on_q;
	logic       wrap;

	assign wrap = (cnt_q == half_q);

	// -----------------------------------------------------------------
	// half-period counter
	// -----------------------------------------------------------------
	// new settings load only at the end of a high half or at a wrap while the pin
	// is stopped low, so every half period runs complete and no runt pulse can reach the pin
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			cnt_q     <= 6'h00;
			half_q    <= 6'h00;
			on_q      <= 1'b0;
			o_clk_pin <= 1'b0;
		end
		else if (!wrap)
			cnt_q <= cnt_q + 6'h01;
		else
		begin
			cnt_q <= 6'h00;
			if (on_q && !o_clk_pin)
				o_clk_pin <= 1'b1;
			else
			begin
				o_clk_pin <= 1'b0;
				half_q    <= ctl.clk_slow ? SLOW_HALF : {2'b00, ctl.clk_div}; // [RL18]
				on_q      <= ctl.clk_run | ctl.clk_slow;
			end
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	a_div_no_glitch: assert property ( // [RL19]
		!$stable(half_q) |-> $past(wrap) && !o_clk_pin)
		else $error("clock period changed inside a period");
	a_clk_edge_wrap: assert property ( // [RL18]
		!$stable(o_clk_pin) |-> $past(wrap))
		else $error("clock pin toggled before half period ended");
endmodule : uh_divided_clock_pin
`default_nettype wire

/* hdl/uh_irq_out.sv */
// interrupt pin shaping: gate, level or pulse, polarity
`timescale 1ns/100ps
`default_nettype none
`include "uh_params.svh"
module uh_irq_out (
	input  wire logic  i_core_clk,
	input  wire logic  i_reset_n,
	uh_ctl_if.irqgen   ctl,
	output logic       o_irq_pin
);
	localparam logic [1:0] PULSE_CYC = 2'(`UH_IRQ_PULSE_CYC);
	logic [1:0] pcnt_q;
	logic       lvl_q;
	logic       act;
	logic       fire;

	assign fire = ctl.irq_evt & ctl.irq_en;                     // [RL5]
	assign act  = ctl.irq_en & (ctl.irq_pulse ? (pcnt_q != 2'h0) : lvl_q);

	// level latch: a new event wins over an acknowledge in the same cycle
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			lvl_q <= 1'b0;
		else if (fire)
			lvl_q <= 1'b1;
		else if (ctl.irq_clear)
			lvl_q <= 1'b0;
	end

	// pulse timer, restarted by each event
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			pcnt_q <= 2'h0;
		else if (fire && ctl.irq_pulse)
			pcnt_q <= PULSE_CYC;                                  // [RL20]
		else if (pcnt_q != 2'h0)
			pcnt_q <= pcnt_q - 2'h1;
	end

	// registered pin; idles high because reset polarity is active low
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			o_irq_pin <= 1'b1;
		else
			o_irq_pin <= ctl.irq_pol ? act : !act;               // [RL21]
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	a_irq_master_gate: assert property ( // [RL5]
		!ctl.irq_en |=> o_irq_pin == !$past(ctl.irq_pol))
		else $error("interrupt signalled while master gate off");
	a_irq_pulse_len: assert property ( // [RL20]
		fire && ctl.irq_pulse && ctl.irq_pol |=>
		(pcnt_q != 2'h0) [*2] ##1 (pcnt_q == 2'h0 || $past(fire)))
		else $error("interrupt pulse has wrong length");
	c_irq_pulse: cover property (fire && ctl.irq_pulse);
endmodule : uh_irq_out
`default_nettype wire

/* include/uh_ctl_if.sv */
// control bundle from the register bank to clock and interrupt outputs
`timescale 1ns/100ps
`default_nettype none
interface uh_ctl_if;
	uh_pkg::uh_div_t clk_div;   // divider field n
	logic            clk_run;   // divided clock wanted
	logic            clk_slow;  // slow suspend clock wanted
	logic            irq_evt;   // selected interrupt event, one cycle
	logic            irq_en;    // master interrupt gate
	logic            irq_pulse; // 1 = pulsed signalling
	logic            irq_pol;   // 1 = active high
	logic            irq_clear; // level interrupt acknowledged
	modport ctl (output clk_div, clk_run, clk_slow, irq_evt, irq_en,
		irq_pulse, irq_pol, irq_clear);
	modport clkgen (input clk_div, clk_run, clk_slow);
	modport irqgen (input irq_evt, irq_en, irq_pulse, irq_pol, irq_clear);
endinterface : uh_ctl_if
`default_nettype wire

/* include/uh_params.svh */
// register codes, field positions, reset values and timing counts
// Overview of operation
// [RL1] mode register written with code b8, read with b9, one data byte.
// [RL2] in 16-bit bus mode the upper byte of a mode write is dropped.
// [RL3] mode resets to 80h; bus reset keeps bits 7, 3, 2, 1 and 0.
// [RL4] writing 1 then 0 to the suspend trigger bit enters suspend.
// [RL5] interrupt master bit gates every interrupt; at 0 none is signalled.
// [RL6] diagnostic mode interrupts on every nak and every transfer error.
// [RL7] normal mode interrupts on bulk ack and isochronous transfer done.
// [RL8] soft pull-up bit attaches the pull-up unless external pull-up set.
// [RL9] in otg mode the local-connect bit drives the d+ pull-up instead.
// [RL10] config register written with ba, read with bb, low byte first.
// [RL11] low byte holds device control, high byte clock control and divider.
// [RL12] bus reset leaves every config register bit unchanged.
// [RL13] config resets to divider 3, slow-clock disable 1, bits 6 and 2 set.
// [RL14] external pull-up bit says the soft pull-up is not used.
// [RL15] slow clock appears on clock pin 2 ms into suspend unless disabled.
// [RL16] keep-clocks 0 stops oscillator and pll 2 ms into suspend.
// [RL17] firmware clears keep-clocks before suspend to meet current limit.
// [RL18] divider field n sets clock output to 48/(n+1) of the base rate; the code gives core clock/(2(n+1)), each half n+1 cycles.
// [RL19] clock output has no glitch when the divider changes.
// [RL20] interrupt bit 1 selects level at 0, 166 ns pulse at 1; the code pulses for 2 cycles, 200 ns.
// [RL21] interrupt bit 0 selects polarity: 0 active low, 1 active high.
// [RL22] bits 6, 5 set dma request/ack polarity; bit 7 ack-only dma mode.
// [RL23] with bit 3 set, low chip-select wakes the device from suspend.
// [RL24] suspend starts on a written 1-to-0 change of the trigger bit.
// [RL25] firmware writes zero to reserved bits, keeps reset reserved values.
`ifndef UH_PARAMS_SVH
`define UH_PARAMS_SVH
`define UH_CMD_MODE_WR     8'hb8
`define UH_CMD_MODE_RD     8'hb9
`define UH_CMD_HW_WR       8'hba
`define UH_CMD_HW_RD       8'hbb
`define UH_MODE_RST        8'h80
`define UH_MODE_BUS_KEEP   8'h8f
`define UH_MODE_SUSP_BIT   5
`define UH_MODE_IRQ_ON_BIT 3
`define UH_MODE_DIAG_BIT   2
`define UH_MODE_SOFT_BIT   0
`define UH_HW_RST          16'h2344
`define UH_HW_WMASK        16'h7fef
`define UH_HW_EXT_PULL_BIT 14
`define UH_HW_SLOW_DIS_BIT 13
`define UH_HW_KEEP_CLK_BIT 12
`define UH_HW_DIV_MSB      11
`define UH_HW_DIV_LSB      8
`define UH_HW_ACK_ONLY_BIT 7
`define UH_HW_REQ_POL_BIT  6
`define UH_HW_ACK_POL_BIT  5
`define UH_HW_CS_WAKE_BIT  3
`define UH_HW_PULSE_BIT    1
`define UH_HW_POL_BIT      0
`define UH_CORE_HZ         10000000
`define UH_CLK_NS          100
`define UH_SUSP_DELAY_NS   2000000
`define UH_SUSP_CYC        (`UH_SUSP_DELAY_NS / `UH_CLK_NS)
`define UH_IRQ_PULSE_NS    166
`define UH_IRQ_PULSE_CYC   ((`UH_IRQ_PULSE_NS + `UH_CLK_NS - 1) / `UH_CLK_NS)
`define UH_SLOW_HZ         115000
`define UH_SLOW_HALF_CYC   (`UH_CORE_HZ / (2 * `UH_SLOW_HZ))
`endif

/* include/uh_pkg.sv */
// state and field types shared by the mode/config block
package uh_pkg;
	typedef enum logic [2:0] {
		uh_st_idle     = 3'b000,
		uh_st_mode_wr  = 3'b001,
		uh_st_hw_wr_lo = 3'b010,
		uh_st_hw_wr_hi = 3'b011,
		uh_st_mode_rd  = 3'b100,
		uh_st_hw_rd_lo = 3'b101,
		uh_st_hw_rd_hi = 3'b110
	} uh_cmd_e;
	typedef enum logic [1:0] {
		uh_su_run   = 2'b00,
		uh_su_wait  = 2'b01,
		uh_su_sleep = 2'b10
	} uh_susp_e;
	typedef logic [3:0] uh_div_t;
endpackage : uh_pkg

/* verif/tb.sv */
// self-checking bench of the mode and configuration registers
`timescale 1ns/100ps
`default_nettype none
`include "uh_params.svh"
module tb;
	logic        i_core_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        i_usb_bus_reset, i_bus_16bit, i_otg_mode, i_local_connect;
	logic        i_irq_clear, i_resume, i_cmd_valid, i_data_wr, i_data_rd;
	logic [3:0]  evt;
	logic [15:0] i_wdata, o_rdata, q, w, h;
	logic        o_port1_dplus_pullup, o_peripheral_irq_pin, o_suspended;
	logic        o_ack_only_dma_mode, o_osc_pll_stop;
	int          err_total = 0, comparisons = 0, cyc = 0;
	always #50 i_core_clk = ~i_core_clk;
	uh_cfg_top #(.SUSP_CYC(8)) u_dut (.i_core_clk, .i_reset_n,
		.i_usb_bus_reset, .i_bus_16bit, .i_cmd_valid, .i_data_wr,
		.i_data_rd, .i_wdata, .o_rdata, .i_otg_mode, .i_local_connect,
		.i_evt_ack_bulk(evt[0]), .i_evt_iso_done(evt[1]),
		.i_evt_nak(evt[2]), .i_evt_err(evt[3]), .i_irq_clear, .i_resume,
		.i_cs_n(1'b1), .i_dma_request(1'b0), .i_dma_ack_pin(1'b0),
		.o_dma_request_pin(), .o_dma_ack(), .o_ack_only_dma_mode,
		.o_port1_dplus_pullup, .o_divided_clock_pin(),
		.o_peripheral_irq_pin, .o_suspended, .o_osc_pll_stop,
		.o_remote_wakeup());
	uh_host_model u_host (.i_core_clk, .i_rdata(o_rdata),
		.o_cmd_valid(i_cmd_valid), .o_data_wr(i_data_wr),
		.o_data_rd(i_data_rd), .o_wdata(i_wdata));
	task automatic chk(input string n, input logic [15:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic stop_test;
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	// expected pull-up: otg control wins, external pull-up masks soft one
	function automatic logic f_pull(logic otg, lc, logic [15:0] m, hw);
		return otg ? lc : (m[0] & ~hw[14]);
	endfunction : f_pull
	// set mode, fire one event, check the level pin, then acknowledge
	task automatic irq_try(input logic [7:0] m, input logic [3:0] e, x);
		u_host.acc(`UH_CMD_MODE_WR, 1, 1'b1, {8'h00, m}, q);
		evt <= e;
		@(posedge i_core_clk);
		evt <= '0;
		repeat (2) @(negedge i_core_clk);
		chk("irq pin", x, o_peripheral_irq_pin);
		i_irq_clear <= 1'b1;
		@(posedge i_core_clk);
		i_irq_clear <= 1'b0;
	endtask : irq_try
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge i_core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			stop_test();
		end
	end
	initial
	begin
		{i_usb_bus_reset, i_bus_16bit, i_otg_mode, i_local_connect} = '0;
		{i_irq_clear, i_resume, evt} = '0;
		void'($urandom(32'h7f2671c2));
		repeat (5) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		u_host.acc(`UH_CMD_MODE_RD, 1, 1'b0, 16'h0000, q);
		chk("mode reset", 16'h0080, q);
		u_host.acc(`UH_CMD_HW_RD, 2, 1'b0, 16'h0000, q);
		chk("hw reset", 16'h2344, q);
		for (int k = 0; k < 8; k++)
		begin
			w = 16'($urandom) & 16'hffdf;
			h = 16'($urandom) & 16'h7fef;
			i_bus_16bit <= k[0];
			{i_otg_mode, i_local_connect} <= 2'($urandom);
			u_host.acc(`UH_CMD_MODE_WR, 1, 1'b1, w, q);
			u_host.acc(`UH_CMD_HW_WR, k[0] ? 1 : 2, 1'b1, h, q);
			i_usb_bus_reset <= (k > 3);
			@(posedge i_core_clk);
			i_usb_bus_reset <= 1'b0;
			u_host.acc(`UH_CMD_MODE_RD, 1, 1'b0, 16'h0000, q);
			// bus reset keeps only bits 7, 3, 2, 1 and 0 of the mode byte
			chk("mode", {8'h00, w[7:0]} & (k > 3 ? 16'h8f : 16'hff), q);
			u_host.acc(`UH_CMD_HW_RD, k[0] ? 1 : 2, 1'b0, 16'h0000, q);
			chk("hw", h, q);
			chk("pullup", f_pull(i_otg_mode, i_local_connect, w, h),
				o_port1_dplus_pullup);
			chk("ack only", h[7], o_ack_only_dma_mode);
		end
		i_bus_16bit <= 1'b0;
		u_host.acc(`UH_CMD_MODE_WR, 1, 1'b1, 16'h0000, q);
		repeat (2) @(negedge i_core_clk);
		chk("suspend", 16'h0000, o_suspended);
		// firmware clears keep-clocks before suspending
		u_host.acc(`UH_CMD_HW_WR, 2, 1'b1, 16'h2344, q);
		u_host.acc(`UH_CMD_MODE_WR, 1, 1'b1, 16'h0020, q);
		u_host.acc(`UH_CMD_MODE_WR, 1, 1'b1, 16'h0000, q);
		repeat (2) @(negedge i_core_clk);
		chk("suspend", 16'h0001, o_suspended);
		repeat (12) @(negedge i_core_clk);
		chk("osc stop", 16'h0001, o_osc_pll_stop);
		i_resume <= 1'b1;
		@(posedge i_core_clk);
		i_resume <= 1'b0;
		u_host.acc(`UH_CMD_HW_WR, 2, 1'b1, 16'h2301, q);
		irq_try(8'h00, 4'b0001, 1'b0);
		irq_try(8'h08, 4'b0100, 1'b0);
		irq_try(8'h08, 4'b0001, 1'b1);
		irq_try(8'h08, 4'b0010, 1'b1);
		irq_try(8'h0c, 4'b0100, 1'b1);
		irq_try(8'h0c, 4'b1000, 1'b1);
		stop_test();
	end
endmodule : tb
`default_nettype wire

/* verif/uh_host_model.sv */
// host processor model issuing command codes and data strobes
`timescale 1ns/100ps
`default_nettype none
// ----
// host bus driver
// ----
module uh_host_model (
	input  wire logic        i_core_clk,
	input  wire logic [15:0] i_rdata,
	output logic             o_cmd_valid,
	output logic             o_data_wr,
	output logic             o_data_rd,
	output logic      [15:0] o_wdata
);
	initial {o_cmd_valid, o_data_wr, o_data_rd, o_wdata} = '0;
	// one bus cycle; read data is taken at the edge that ends the cycle,
	// before the design's update at that edge lands
	task automatic step(input logic c, w, r, input logic [15:0] d,
		output logic [15:0] q);
		o_cmd_valid <= c;
		o_data_wr   <= w;
		o_data_rd   <= r;
		o_wdata     <= d;
		@(posedge i_core_clk);
		q = i_rdata;
	endtask : step
	// code then n units; unused upper lines carry a pattern, not old data
	task automatic acc(input logic [7:0] code, input int n, input logic wr,
		input logic [15:0] d, output logic [15:0] q);
		logic [15:0] b;
		logic [15:0] t;
		q = '0;
		b = d;
		step(1'b1, 1'b0, 1'b0, {~code, code}, t);
		for (int i = 0; i < n; i++)
		begin
			b = (n == 2) ? {~d[8*i+:8], d[8*i+:8]} : d;
			step(1'b0, wr, !wr, b, t);
			q = q | ((n == 2) ? {8'h00, t[7:0]} << (8*i) : t);
		end
		step(1'b0, 1'b0, 1'b0, ~b, t);
	endtask : acc
endmodule : uh_host_model
`default_nettype wire
